// *** reset_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Reset pin and strap model.
module reset_partner (
	input wire logic strap_watchdog_en,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	output logic reset_pin_in,
	output logic strap_halt_en
);
	// The pin has a pull-up, so it rests high when the pulldown is off.
	assign reset_pin_in = reset_pin_oe ? reset_pin_out : 1'b1;
	// Halt would freeze the watchdog, so it is off while that runs.
	assign strap_halt_en = !strap_watchdog_en;
endmodule
`default_nettype wire

// *** watchdog_and_internal_resets.sv ***
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_internal_resets #(
	parameter int unsigned WDOG_TIMEOUT = wdog_pkg::WDOG_TIMEOUT_DEFAULT,
	parameter logic [7:0] VECTOR_BYTE = wdog_pkg::VECTOR_BYTE_RESET
) (
	input wire logic core_clk,
	input wire logic arst_n,
	// Avalon-MM slave.
	input wire logic [15:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// CPU core observation, same clock.
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic halt_exec,
	input wire logic halt_wake_irq,
	// Pins, straps and supply detector, asynchronous.
	input wire logic strap_watchdog_en,
	input wire logic strap_halt_en,
	input wire logic strap_low_supply_en,
	input wire logic supply_below_fall,
	input wire logic supply_above_rise,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// Device-wide reset and clock gate.
	output logic internal_reset,
	output logic clocks_halted
);

	// ==========================================================
	// Input synchronisers
	// ==========================================================

	logic [5:0] async_in;
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic wdog_en;
	logic halt_en;
	logic ls_en;
	logic below_fall;
	logic above_rise;
	logic pin_low;

	// Every outside level passes two flops before any logic.
	assign async_in = {strap_watchdog_en, strap_halt_en,
		strap_low_supply_en, supply_below_fall,
		supply_above_rise, reset_pin_in};

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_a <= 6'h01;
			sync_b <= 6'h01;
		end else begin
			sync_a <= async_in;
			sync_b <= sync_a;
		end
	end

	// Straps are fixed after power-up, so a sampled copy is safe.
	assign wdog_en = sync_b[5];
	assign halt_en = sync_b[4];
	assign ls_en = sync_b[3];
	assign below_fall = sync_b[2];
	assign above_rise = sync_b[1];
	assign pin_low = !sync_b[0];

	// ==========================================================
	// Avalon slave
	// ==========================================================

	// Counter width has to be known before the counter is declared.
	localparam int WDOG_W = wdog_pkg::WDOG_W;

	logic ack;
	logic req;
	logic hit_clear;
	logic hit_status;
	logic hit_count;
	logic wr_done;
	logic sw_clear;
	logic cause_wr;
	logic [31:0] next_readdata;
	logic [31:0] status_word;
	logic [WDOG_W-1:0] wd_cnt;
	wdog_pkg::reset_cause_t causes;
	wdog_pkg::halt_state_t state;
	logic ls_active;

	// One wait cycle: the request is seen, then answered.
	assign req = read | write;
	assign waitrequest = req & !ack;
	assign wr_done = write & ack;

	// Address decode.
	assign hit_clear = (address == wdog_pkg::CLEAR_ADDR);
	assign hit_status = (address == wdog_pkg::STATUS_ADDR);
	assign hit_count = (address == wdog_pkg::COUNT_ADDR);

	// Only a write of zero in the low bit services the dog.
	assign sw_clear = wr_done & hit_clear & byteenable[0]
		& !writedata[wdog_pkg::CLEAR_BIT];
	assign cause_wr = wr_done & hit_status & byteenable[0];

	assign status_word = {23'h000000,
		state == wdog_pkg::HALTED, ls_en, halt_en, wdog_en,
		ls_active, causes};

	// Reading 3FF0 gives the programmed byte and touches nothing.
	always_comb begin
		next_readdata = 32'h00000000;
		if (hit_clear) begin
			next_readdata = {24'h000000, VECTOR_BYTE};
		end else if (hit_status) begin
			next_readdata = status_word;
		end else if (hit_count) begin
			next_readdata = {15'h0000, wd_cnt};
		end
	end

	// Read data is captured in the wait cycle, stable at the answer.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack <= 1'b0;
			readdata <= 32'h00000000;
		end else begin
			ack <= req & !ack;
			if (read & !ack) begin
				readdata <= next_readdata;
			end
		end
	end

	// ==========================================================
	// Reset sources
	// ==========================================================

	logic illegal_fetch;
	logic halt_disabled;
	logic wd_expire;
	logic halt_enter;
	logic any_event;
	logic [11:0] ls_delay;
	logic next_ls_active;
	logic [11:0] next_ls_delay;
	logic ls_done;

	// Code may never run from the I/O page or the hole.
	assign illegal_fetch = fetch_valid
		& ((fetch_addr >= wdog_pkg::IO_LO
		& fetch_addr <= wdog_pkg::IO_HI)
		| (fetch_addr >= wdog_pkg::HOLE_LO
		& fetch_addr <= wdog_pkg::HOLE_HI));

	// A halt the straps forbid becomes a reset instead.
	assign halt_disabled = halt_exec & !halt_en;
	assign halt_enter = halt_exec & halt_en
		& (state == wdog_pkg::RUN);

	assign any_event = wd_expire | illegal_fetch
		| halt_disabled;

	// Low supply always recovers through the full delay, because
	// the core supply level cannot be trusted on the way back up.
	assign ls_done = (ls_delay == wdog_pkg::STARTUP_CYCLES - 12'h001);

	always_comb begin
		next_ls_active = ls_active;
		next_ls_delay = ls_delay;
		if (ls_en & below_fall) begin
			next_ls_active = 1'b1;
			next_ls_delay = 12'h000;
		end else if (ls_active & above_rise) begin
			if (ls_done) begin
				next_ls_active = 1'b0;
			end else begin
				next_ls_delay = ls_delay + 12'h001;
			end
		end else if (ls_active) begin
			next_ls_delay = 12'h000;
		end
	end

	// Starting active gives a power-on delay after arst_n too.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ls_active <= 1'b1;
			ls_delay <= 12'h000;
		end else begin
			ls_active <= next_ls_active;
			ls_delay <= next_ls_delay;
		end
	end

	// ==========================================================
	// Pin pulldown and internal reset
	// ==========================================================

	logic [2:0] pd_cnt;
	logic [2:0] next_pd_cnt;
	logic next_pin_oe;
	logic next_reset;

	// Stretch short events so the pin is seen low long enough.
	assign next_pd_cnt = any_event ? wdog_pkg::PULLDOWN_CYCLES
		: (pd_cnt != 3'h0) ? pd_cnt - 3'h1 : 3'h0;

	assign next_pin_oe = (next_pd_cnt != 3'h0)
		| next_ls_active;

	// The pin's own level only feeds the reset, never the
	// pulldown, so our drive cannot latch itself on.
	assign next_reset = next_pin_oe | pin_low;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pd_cnt <= 3'h0;
			reset_pin_oe <= 1'b1;
			reset_pin_out <= 1'b0;
			internal_reset <= 1'b1;
		end else begin
			pd_cnt <= next_pd_cnt;
			reset_pin_oe <= next_pin_oe;
			reset_pin_out <= 1'b0;
			internal_reset <= next_reset;
		end
	end

	// ==========================================================
	// Halt sequencing
	// ==========================================================

	logic [11:0] wake_cnt;
	logic [11:0] next_wake_cnt;
	wdog_pkg::halt_state_t next_state;
	logic wake_done;

	assign wake_done =
		(wake_cnt == wdog_pkg::STARTUP_CYCLES - 12'h001);

	always_comb begin
		next_state = state;
		next_wake_cnt = 12'h000;
		case (state)
			wdog_pkg::RUN: begin
				if (halt_enter) begin
					next_state = wdog_pkg::HALTED;
				end
			end
			wdog_pkg::HALTED: begin
				if (internal_reset) begin
					next_state = wdog_pkg::WAKE_RST;
				end else if (halt_wake_irq) begin
					next_state = wdog_pkg::WAKE_IRQ;
				end
			end
			default: begin
				if (internal_reset
					& state == wdog_pkg::WAKE_IRQ) begin
					next_state = wdog_pkg::WAKE_RST;
				end else if (wake_done) begin
					next_state = wdog_pkg::RUN;
				end else begin
					next_wake_cnt = wake_cnt + 12'h001;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= wdog_pkg::RUN;
			wake_cnt <= 12'h000;
		end else begin
			state <= next_state;
			wake_cnt <= next_wake_cnt;
		end
	end

	// Oscillator is off while halted; downstream gates its clocks.
	assign clocks_halted = (state == wdog_pkg::HALTED);

	// ==========================================================
	// Watchdog counter
	// ==========================================================

	localparam logic [WDOG_W-1:0] WD_LAST =
		WDOG_W'(WDOG_TIMEOUT - 1);

	logic wd_hold;
	logic [WDOG_W-1:0] next_wd_cnt;

	// Idle is not listed here: the counter runs through it.
	assign wd_hold = !wdog_en | internal_reset | sw_clear
		| halt_enter
		| (state == wdog_pkg::HALTED)
		| (state == wdog_pkg::WAKE_RST);

	// Interrupt wake and plain run both count.
	assign wd_expire = !wd_hold & (wd_cnt == WD_LAST);

	assign next_wd_cnt = (wd_hold | wd_expire) ? '0
		: wd_cnt + 1'b1;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wd_cnt <= '0;
		end else begin
			wd_cnt <= next_wd_cnt;
		end
	end

	// ==========================================================
	// Reset cause flags
	// ==========================================================

	wdog_pkg::reset_cause_t cause_set;
	wdog_pkg::reset_cause_t next_causes;

	assign cause_set = '{low_supply: ls_active & !next_ls_active
		? 1'b0 : ls_active,
		halt_disabled: halt_disabled,
		illegal_fetch: illegal_fetch,
		watchdog: wd_expire};

	// Write one to clear; a new event in the same cycle wins.
	assign next_causes = (causes
		& ~(cause_wr ? writedata[3:0] : 4'h0)) | cause_set;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			causes <= '0;
		end else begin
			causes <= next_causes;
		end
	end

endmodule
`default_nettype wire

// *** watchdog_and_internal_resets_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Reset source checker.
module watchdog_and_internal_resets_props #(
	parameter int unsigned WDOG_TIMEOUT = 64,
	parameter logic [7:0] VECTOR_BYTE = 8'h00
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [15:0] address,
	input wire logic read,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_addr,
	input wire logic halt_exec,
	input wire logic strap_halt_en,
	input wire logic strap_low_supply_en,
	input wire logic supply_above_rise,
	input wire logic supply_below_fall,
	input wire logic reset_pin_oe,
	input wire logic internal_reset,
	input wire logic clocks_halted
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic [12:0] rise_cnt;
	// Cycles of good supply; saturates so long runs never wrap.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			rise_cnt <= 13'h0000;
		else if (!supply_above_rise || supply_below_fall)
			rise_cnt <= 13'h0000;
		else if (rise_cnt != 13'h1FFF)
			rise_cnt <= rise_cnt + 13'h0001;
	end
	sequence s_reset_on;
		internal_reset && reset_pin_oe;
	endsequence
	a_io_fetch: assert property (
		fetch_valid && fetch_addr <= 16'h003F |=> s_reset_on)
		else $error("io fetch");
	a_hole_fetch: assert property (
		fetch_valid && fetch_addr >= 16'h02C0
		&& fetch_addr <= 16'h0CFF |=> s_reset_on)
		else $error("hole fetch");
	a_pin_stretch: assert property (
		$rose(reset_pin_oe) |-> reset_pin_oe [*4])
		else $error("pin stretch");
	a_oe_resets: assert property (
		reset_pin_oe |-> internal_reset)
		else $error("oe without reset");
	// The design sees the halt strap two flops late.
	a_halt_off: assert property (
		halt_exec && !$past(strap_halt_en, 2) && !clocks_halted
		&& !internal_reset |=> s_reset_on)
		else $error("halt reset");
	a_supply_hold: assert property (
		$fell(internal_reset) && strap_low_supply_en
		|-> rise_cnt >= 13'h0FE0)
		else $error("supply hold");
	a_one_wait: assert property (
		$rose(read) |-> waitrequest ##1 !waitrequest)
		else $error("wait count");
	a_vector_read: assert property (
		read && !waitrequest && address == 16'h3FF0
		|-> readdata[7:0] == VECTOR_BYTE)
		else $error("vector byte");
endmodule
`default_nettype wire

// *** watchdog_and_internal_resets_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench.
module watchdog_and_internal_resets_tb;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [15:0] address = 16'h0000;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h00000000;
	logic [3:0] byteenable = 4'hF;
	logic fetch_valid = 1'b0;
	logic [15:0] fetch_addr = 16'h0000;
	logic halt_exec = 1'b0;
	logic halt_wake_irq = 1'b0;
	logic strap_low_supply_en = 1'b1;
	logic strap_watchdog_en = 1'b0;
	logic supply_below_fall = 1'b0;
	logic supply_above_rise = 1'b1;
	logic [31:0] readdata;
	logic waitrequest, strap_halt_en, reset_pin_in, reset_pin_out;
	logic reset_pin_oe, internal_reset, clocks_halted;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;
	int n;
	logic [31:0] q;
	watchdog_and_internal_resets #(
		.WDOG_TIMEOUT(64)
	) dut_u (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.address(address),
		.read(read),
		.write(write),
		.writedata(writedata),
		.byteenable(byteenable),
		.readdata(readdata),
		.waitrequest(waitrequest),
		.fetch_valid(fetch_valid),
		.fetch_addr(fetch_addr),
		.halt_exec(halt_exec),
		.halt_wake_irq(halt_wake_irq),
		.strap_watchdog_en(strap_watchdog_en),
		.strap_halt_en(strap_halt_en),
		.strap_low_supply_en(strap_low_supply_en),
		.supply_below_fall(supply_below_fall),
		.supply_above_rise(supply_above_rise),
		.reset_pin_in(reset_pin_in),
		.reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe),
		.internal_reset(internal_reset),
		.clocks_halted(clocks_halted)
	);
	reset_partner partner_u (
		.strap_watchdog_en(strap_watchdog_en),
		.reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe),
		.reset_pin_in(reset_pin_in),
		.strap_halt_en(strap_halt_en)
	);
	// Free-running clock.
	always #50 core_clk = ~core_clk;
	// Cut a hang short well past the longest expected run.
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			results();
		end
	end
	task automatic results();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One Avalon access, held until waitrequest is sampled low at an
	// edge; only the bench timeout ends a wait that never answers.
	task automatic bus(input logic w, input logic [15:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		read <= !w;
		write <= w;
		do begin
			@(posedge core_clk);
		end while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wait_rst(input logic lvl, input int lim, output int c);
		c = 0;
		while (internal_reset !== lvl && c < lim) begin
			@(negedge core_clk);
			c++;
		end
	endtask
	task automatic t_fetch();
		logic [15:0] adr [7] = '{16'h0000, 16'h003F, 16'h02C0,
			16'h0CFF, 16'h0040, 16'h02BF, 16'h0D00};
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk);
			fetch_valid <= 1'b1;
			fetch_addr <= adr[i];
			@(posedge core_clk);
			fetch_valid <= 1'b0;
			wait_rst(1'b1, 3, n);
			chk({31'h0, n < 3}, {31'h0, i < 4});
			wait_rst(1'b0, 20, n);
		end
		// Power-on and fetch causes stick until written with ones.
		bus(1'b0, wdog_pkg::STATUS_ADDR, 32'h00000000, q);
		chk(q, 32'h000000CA);
		bus(1'b1, wdog_pkg::STATUS_ADDR, 32'h0000000F, q);
		bus(1'b0, wdog_pkg::STATUS_ADDR, 32'h00000000, q);
		chk(q, 32'h000000C0);
		$display("fetch done");
	endtask
	task automatic t_wdog();
		@(posedge core_clk);
		strap_watchdog_en <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			repeat (30) @(posedge core_clk);
			bus(1'b1, wdog_pkg::CLEAR_ADDR, 32'h00000000, q);
			chk({31'h0, internal_reset}, 32'h0);
		end
		bus(1'b0, wdog_pkg::CLEAR_ADDR, 32'h00000000, q);
		chk({24'h0, q[7:0]}, {24'h0, wdog_pkg::VECTOR_BYTE_RESET});
		bus(1'b1, wdog_pkg::CLEAR_ADDR, 32'h00000001, q);
		wait_rst(1'b1, 80, n);
		chk({31'h0, n >= 52 && n <= 62}, 32'h1);
		chk({31'h0, reset_pin_oe}, 32'h1);
		chk({31'h0, reset_pin_out}, 32'h0);
		wait_rst(1'b0, 20, n);
		$display("watchdog done");
	endtask
	task automatic t_halt();
		@(posedge core_clk);
		halt_exec <= 1'b1;
		@(posedge core_clk);
		halt_exec <= 1'b0;
		wait_rst(1'b1, 3, n);
		chk({31'h0, n < 3}, 32'h1);
		wait_rst(1'b0, 20, n);
		@(posedge core_clk);
		strap_watchdog_en <= 1'b0;
		$display("halt done");
	endtask
	// Permitted halt freezes clocks; an interrupt brings them back.
	task automatic t_stop();
		repeat (3) @(posedge core_clk);
		halt_exec <= 1'b1;
		@(posedge core_clk);
		halt_exec <= 1'b0;
		@(negedge core_clk);
		chk({31'h0, clocks_halted}, 32'h1);
		chk({31'h0, internal_reset}, 32'h0);
		bus(1'b0, wdog_pkg::STATUS_ADDR, 32'h00000000, q);
		chk({31'h0, q[8]}, 32'h1);
		@(posedge core_clk);
		halt_wake_irq <= 1'b1;
		@(posedge core_clk);
		halt_wake_irq <= 1'b0;
		@(negedge core_clk);
		chk({31'h0, clocks_halted}, 32'h0);
		$display("stop done");
	endtask
	task automatic t_supply();
		// With the strap off a supply dip must not reset.
		@(posedge core_clk);
		strap_low_supply_en <= 1'b0;
		repeat (3) @(posedge core_clk);
		supply_below_fall <= 1'b1;
		supply_above_rise <= 1'b0;
		wait_rst(1'b1, 10, n);
		chk(n, 10);
		@(posedge core_clk);
		supply_below_fall <= 1'b0;
		supply_above_rise <= 1'b1;
		repeat (3) @(posedge core_clk);
		strap_low_supply_en <= 1'b1;
		repeat (3) @(posedge core_clk);
		supply_below_fall <= 1'b1;
		supply_above_rise <= 1'b0;
		wait_rst(1'b1, 6, n);
		chk({31'h0, n < 6}, 32'h1);
		@(posedge core_clk);
		supply_below_fall <= 1'b0;
		supply_above_rise <= 1'b1;
		wait_rst(1'b0, 6000, n);
		chk({31'h0, n >= 4064}, 32'h1);
		$display("supply done");
	endtask
	// Main sequence: power-up delay first, then each source in turn.
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		wait_rst(1'b0, 6000, n);
		chk({31'h0, n >= 4064 && n < 4080}, 32'h1);
		bus(1'b0, wdog_pkg::CLEAR_ADDR, 32'h00000000, q);
		chk({24'h0, q[7:0]}, {24'h0, wdog_pkg::VECTOR_BYTE_RESET});
		bus(1'b0, 16'h1234, 32'h00000000, q);
		chk(q, 32'h00000000);
		$display("startup done");
		t_fetch();
		t_wdog();
		t_halt();
		t_stop();
		t_supply();
		results();
	end
endmodule
bind watchdog_and_internal_resets
	watchdog_and_internal_resets_props #(
	.WDOG_TIMEOUT(WDOG_TIMEOUT),
	.VECTOR_BYTE(VECTOR_BYTE)
) props_u (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.address(address),
	.read(read),
	.readdata(readdata),
	.waitrequest(waitrequest),
	.fetch_valid(fetch_valid),
	.fetch_addr(fetch_addr),
	.halt_exec(halt_exec),
	.strap_halt_en(strap_halt_en),
	.strap_low_supply_en(strap_low_supply_en),
	.supply_above_rise(supply_above_rise),
	.supply_below_fall(supply_below_fall),
	.reset_pin_oe(reset_pin_oe),
	.internal_reset(internal_reset),
	.clocks_halted(clocks_halted)
);
`default_nettype wire

// *** wdog_pkg.sv ***
// Operation
// - Unserviced watchdog expires and resets whole chip.
// - Writing zero to clear bit restarts timeout.
// - Clear bit is bit 0 at 3FF0.
// - Reading 3FF0 returns programmed data, no effect.
// - Strap enables watchdog; active in all modes. The code holds the counter cleared while halted and during reset wake.
// - Watchdog keeps counting during idle mode.
// - Entering halt clears the watchdog counter.
// - Reset wake holds counter cleared 4064 cycles.
// - Interrupt wake counts during 4064 start-up cycles.
// - Permitted halt stops all clocks, watchdog too.
// - Watchdog timeout turns on reset pin pulldown.
// - Low supply resets; releases after rise delay.
// - Transient low supply holds reset 4064 cycles.
// - Strap can suppress the low-supply reset.
// - Low-supply reset pulls pin; others extend reset.
// - Reset persists while any other source active.
// - Fetch from 02C0-0CFF or 0000-003F resets.
// - Illegal-address reset turns on pin pulldown.
// - Disabled halt instruction resets, pulls pin low.
// - Pin low for reset length or 4 cycles.
`default_nettype none
package wdog_pkg;
	// Register byte addresses on the Avalon slave.
	localparam logic [15:0] CLEAR_ADDR = 16'h3FF0;
	localparam logic [15:0] STATUS_ADDR = 16'h3FE0;
	localparam logic [15:0] COUNT_ADDR = 16'h3FE4;
	localparam int CLEAR_BIT = 0;
	// Arbitrary value standing for the user byte programmed at 3FF0.
	localparam logic [7:0] VECTOR_BYTE_RESET = 8'hA5;

	// Status field positions; causes occupy bits 3:0.
	localparam int STAT_LS_ACTIVE = 4;
	localparam int STAT_WDOG_EN = 5;
	localparam int STAT_HALT_EN = 6;
	localparam int STAT_LS_EN = 7;
	localparam int STAT_HALTED = 8;

	// Fetch ranges that are not allowed to hold code.
	localparam logic [15:0] IO_LO = 16'h0000;
	localparam logic [15:0] IO_HI = 16'h003F;
	localparam logic [15:0] HOLE_LO = 16'h02C0;
	localparam logic [15:0] HOLE_HI = 16'h0CFF;

	// Timing counts in bus clock cycles.
	localparam logic [11:0] STARTUP_CYCLES = 12'hFE0;
	localparam logic [2:0] PULLDOWN_CYCLES = 3'h4;
	localparam int WDOG_TIMEOUT_DEFAULT = 65536;
	localparam int WDOG_W = 17;

	typedef struct packed {
		logic low_supply;
		logic halt_disabled;
		logic illegal_fetch;
		logic watchdog;
	} reset_cause_t;

	typedef enum logic [1:0] {
		RUN,
		HALTED,
		WAKE_IRQ,
		WAKE_RST
	} halt_state_t;
endpackage
`default_nettype wire

// *** wdog_pkg_note_none.sv ***
`timescale 1ns/1ps
